// File: inc/pts_params.svh
// offsets, field positions, reset values and timing of the threshold stage
`ifndef PTS_PARAMS_SVH
`define PTS_PARAMS_SVH
// register byte offsets; arrays step by four per magnitude
`define PTS_A_CTRL 8'h00
`define PTS_A_MODE 8'h04
`define PTS_A_THR 8'h08
`define PTS_A_CTHR 8'h14
`define PTS_A_HYS 8'h18
`define PTS_A_BLK 8'h24
`define PTS_A_SCL 8'h30
`define PTS_A_OPD 8'h3C
`define PTS_A_RLD 8'h40
`define PTS_A_IST 8'h44
`define PTS_A_IMSK 8'h48
`define PTS_A_COND 8'h4C
`define PTS_A_REMAIN 8'h50
`define PTS_A_EXPECT 8'h54
`define PTS_A_SCALED 8'h58
`define PTS_A_RATIO 8'h64
// field positions in the control and mode registers
`define PTS_F_SEL 0
`define PTS_F_BEHAV 4
`define PTS_F_MODE_STEP 4
// reset values
`define PTS_RST_THR 48'h0000_0000_0064
`define PTS_RST_HYS 20'h0_7530
`define PTS_RST_SCL 32'h0001_0000
`define PTS_RST_OPD 21'h00_0028
`define PTS_RST_RLD 21'h00_003C
// value limits and fixed-point scale factors
`define PTS_MAX 64'h0000_000B_A43B_7400
`define PTS_TMAX 21'h1B_7740
`define PTS_PCT 32'h000F_4240
`define PTS_HYS_RECIP 32'h0010_C6F8
`define PTS_HYS_SHIFT 40
`define PTS_RATIO_ONE 32'h0000_2710
// timing: figures in ns, counts derived in the top
`define PTS_CLK_NS 8
`define PTS_TICK_NS 1000000
`define PTS_WIN_NS 20000000
`endif

// File: inc/pts_pkg.sv
// types shared by the threshold stage modules
package pts_pkg;
  typedef enum logic [2:0] {
    PTS_OVER, PTS_OVER_ABS, PTS_UNDER, PTS_UNDER_ABS,
    PTS_DPCT_SGN, PTS_DPCT_ABS, PTS_DVAL_SGN, PTS_DVAL_ABS
  } pts_mode_e;
  typedef enum logic [2:0] {
    PTS_NORMAL, PTS_START, PTS_TRIP, PTS_BLOCKED,
    PTS_REL_START, PTS_REL_TRIP, PTS_REL_BLOCK
  } pts_state_e;
  typedef enum logic [1:0] {
    PTS_C_NORMAL, PTS_C_START, PTS_C_TRIP, PTS_C_BLOCKED
  } pts_cond_e;
  typedef enum logic [2:0] {
    PTS_B_NONE, PTS_B_ON, PTS_B_BLOCKED, PTS_B_TEST, PTS_B_TEST_BLK, PTS_B_OFF
  } pts_behav_e;
endpackage

// File: logic/pts_compare.sv
// one magnitude comparator with release hysteresis
`timescale 1ns/1ps
`default_nettype none
`include "pts_params.svh"
module pts_compare #(
  parameter int DW = 48
) (
  input wire logic signed [DW-1:0] value,
  input wire logic signed [DW-1:0] delta,
  input wire logic signed [DW-1:0] prev,
  input wire pts_pkg::pts_mode_e mode,
  input wire logic signed [DW-1:0] thr,
  input wire logic [19:0] hys,
  input wire logic signed [DW-1:0] blk_lim,
  input wire logic held,
  output logic pick
);
  localparam int W2 = 2 * DW + 24;
  logic signed [W2-1:0] x, lvl, band, thw, tha, pv, xv, xd;
  logic over, lim_ok;
  // level chosen by mode; once picked up, band lowers the level in over comparisons and raises it in under ones
  always_comb
  begin
    thw = W2'(thr);
    tha = (thw < 0) ? -thw : thw;
    band = (tha * W2'(hys) * W2'(`PTS_HYS_RECIP)) >>> `PTS_HYS_SHIFT; // [RQ10]
    xv = W2'(value);
    xd = W2'(delta);
    pv = (W2'(prev) < 0) ? -W2'(prev) : W2'(prev);
    x = xv;
    lvl = thw;
    over = 1'b1;
    lim_ok = 1'b1;
    case (mode) // [RQ8]
      pts_pkg::PTS_OVER: x = xv;
      pts_pkg::PTS_OVER_ABS: x = (xv < 0) ? -xv : xv;
      pts_pkg::PTS_UNDER:
      begin
        over = 1'b0;
        lim_ok = (xv >= W2'(blk_lim)); // [RQ15]
      end
      pts_pkg::PTS_UNDER_ABS:
      begin
        over = 1'b0;
        x = (xv < 0) ? -xv : xv;
        lim_ok = (x >= W2'(blk_lim)); // [RQ15]
      end
      // percent: change times 1e6 against threshold times old value
      pts_pkg::PTS_DPCT_SGN:
      begin
        x = xd * W2'(`PTS_PCT); // [RQ14]
        lvl = thw * pv;
        band = band * pv;
        over = (thw >= 0);
      end
      pts_pkg::PTS_DPCT_ABS:
      begin
        x = ((xd < 0) ? -xd : xd) * W2'(`PTS_PCT); // [RQ14]
        lvl = tha * pv;
        band = band * pv;
      end
      pts_pkg::PTS_DVAL_SGN:
      begin
        x = xd; // [RQ14]
        over = (thw >= 0);
      end
      pts_pkg::PTS_DVAL_ABS:
      begin
        x = (xd < 0) ? -xd : xd; // [RQ14]
        lvl = tha;
      end
      default: x = xv;
    endcase
    // hysteresis only while already picked up
    if (over)
      pick = lim_ok && (x > (held ? lvl - band : lvl)); // [RQ18] [RQ9]
    else
      pick = lim_ok && (x < (held ? lvl + band : lvl)); // [RQ18]
  end
endmodule
`default_nettype wire

// File: logic/pts_divider.sv
// serial unsigned divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
module pts_divider #(
  parameter int NW = 64,
  parameter int DW = 48
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [NW-1:0] num,
  input wire logic [DW-1:0] den,
  output logic done,
  output logic [NW-1:0] quo
);
  logic [DW:0] rem_ff;
  logic [DW-1:0] den_ff;
  logic [7:0] cnt_ff;
  logic [DW:0] sh;
  // divisor latched at start so the caller may change its mux
  assign sh = {rem_ff[DW-1:0], quo[NW-1]};
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rem_ff <= '0;
      den_ff <= '0;
      cnt_ff <= '0;
      quo <= '0;
      done <= 1'b0;
    end
    else
    begin
      done <= (cnt_ff == 8'h01);
      if (start)
      begin
        quo <= num;
        den_ff <= den;
        rem_ff <= '0;
        cnt_ff <= 8'(NW);
      end
      else if (cnt_ff != 8'h00)
      begin
        cnt_ff <= cnt_ff - 8'h01;
        if (sh >= {1'b0, den_ff})
        begin
          rem_ff <= sh - {1'b0, den_ff};
          quo <= {quo[NW-2:0], 1'b1};
        end
        else
        begin
          rem_ff <= sh;
          quo <= {quo[NW-2:0], 1'b0};
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: logic/pts_stage.sv
// programmable threshold stage: scaling, compare, timers, registers
`timescale 1ns/1ps
`default_nettype none
`include "pts_params.svh"
// Notes on behaviour
// (RQ1) up to three selected measurements, own thresholds
// (RQ2) scaled value is measurement times multiplier, clamped
// (RQ3) ratios to threshold exposed, same clamp
// (RQ4) condition code normal, start, trip, blocked
// (RQ5) behaviour code shown only when allowed
// (RQ6) remaining time to trip counts down
// (RQ7) expected operating time reported signed
// (RQ8) eight comparator modes per magnitude, default over
// (RQ9) signed pick-up threshold, default 0.01
// (RQ10) release hysteresis relative to threshold, default 3%
// (RQ11) operate delay, default 40 ms
// (RQ12) release delay, default 60 ms
// (RQ13) start only when pick-up and not blocked
// (RQ14) delta modes use change over 20 ms
// (RQ15) under modes inactive below blocking limit
// (RQ16) late blocking drops start, runs release
// (RQ17) trip after operate delay; release delay clears
// (RQ18) pick-up drops past hysteresis band only
module pts_stage #(
  parameter int DW = 48,
  parameter int TICK_CYC = `PTS_TICK_NS / `PTS_CLK_NS,
  parameter int WIN_CYC = `PTS_WIN_NS / `PTS_CLK_NS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] bus_addr,
  input wire logic [DW-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [DW-1:0] bus_rdata,
  input wire logic signed [DW-1:0] meas_value_0,
  input wire logic signed [DW-1:0] meas_value_1,
  input wire logic signed [DW-1:0] meas_value_2,
  input wire logic block_in,
  input wire logic allow_individual_mode,
  output logic start_out,
  output logic trip_out,
  output logic blocked_out,
  output logic irq
);
  localparam int WW = DW + 16;
  localparam logic signed [WW-1:0] VMAX = WW'(`PTS_MAX);
  logic signed [DW-1:0] meas [3];
  logic signed [DW-1:0] thr_ff [3];
  logic signed [DW-1:0] blk_ff [3];
  logic signed [31:0] scl_ff [3];
  logic [19:0] hys_ff [3];
  pts_pkg::pts_mode_e mode_ff [3];
  logic signed [DW-1:0] cthr_ff;
  logic [2:0] sel_ff;
  pts_pkg::pts_behav_e behav_ff;
  logic [20:0] opd_ff, rld_ff;
  logic [2:0] ist_ff, imsk_ff;
  logic signed [DW-1:0] scaled_ff [3];
  logic signed [DW-1:0] prev_ff [3];
  logic signed [DW-1:0] ref_ff [3];
  logic signed [DW-1:0] delta_ff [3];
  logic signed [DW-1:0] ratio_ff [4];
  logic signed [DW-1:0] calc_ff;
  logic [2:0] pick, held_ff;
  logic pick_any, blk_eff, off, test;
  logic [31:0] win_ff, tick_ff;
  logic win_tick, ms_tick;
  pts_pkg::pts_state_e state_ff, nxt_state;
  pts_pkg::pts_cond_e cond_ff, nxt_cond;
  logic [20:0] op_cnt_ff, rl_cnt_ff, remain_ff;
  logic signed [21:0] expect_ff;
  logic [1:0] rsel_ff;
  logic first_ff, neg_ff, div_go, div_done;
  logic go_ff, blk_in_ff;
  logic [WW-1:0] div_num, div_quo;
  logic [DW-1:0] div_den;
  logic signed [DW-1:0] rv, rt;
  logic [2:0] ev;

  // clamp a wide signed value into the reported range
  function automatic logic signed [DW-1:0] sat(input logic signed [WW-1:0] v);
    if (v > VMAX)
      return DW'(VMAX);
    else if (v < -VMAX)
      return DW'(-VMAX);
    else
      return DW'(v);
  endfunction

  assign meas[0] = meas_value_0;
  assign meas[1] = meas_value_1;
  assign meas[2] = meas_value_2;

  // software writes; bits above each field are dropped
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < 3; i++)
      begin
        thr_ff[i] <= DW'(`PTS_RST_THR); // [RQ9]
        hys_ff[i] <= `PTS_RST_HYS; // [RQ10]
        blk_ff[i] <= '0;
        scl_ff[i] <= `PTS_RST_SCL;
        mode_ff[i] <= pts_pkg::PTS_OVER; // [RQ8]
      end
      cthr_ff <= DW'(`PTS_RST_THR);
      sel_ff <= 3'h1;
      behav_ff <= pts_pkg::PTS_B_ON;
      opd_ff <= `PTS_RST_OPD; // [RQ11]
      rld_ff <= `PTS_RST_RLD; // [RQ12]
      imsk_ff <= '0;
    end
    else if (bus_wr)
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (bus_addr == 8'(`PTS_A_THR + 4 * i))
          thr_ff[i] <= bus_wdata;
        if (bus_addr == 8'(`PTS_A_HYS + 4 * i))
          hys_ff[i] <= bus_wdata[19:0];
        if (bus_addr == 8'(`PTS_A_BLK + 4 * i))
          blk_ff[i] <= bus_wdata;
        if (bus_addr == 8'(`PTS_A_SCL + 4 * i))
          scl_ff[i] <= bus_wdata[31:0];
        if (bus_addr == `PTS_A_MODE)
          mode_ff[i] <= pts_pkg::pts_mode_e'(bus_wdata[`PTS_F_MODE_STEP * i +: 3]);
      end
      case (bus_addr)
        `PTS_A_CTRL:
        begin
          sel_ff <= bus_wdata[`PTS_F_SEL +: 3]; // [RQ1]
          behav_ff <= pts_pkg::pts_behav_e'(bus_wdata[`PTS_F_BEHAV +: 3]);
        end
        `PTS_A_CTHR: cthr_ff <= bus_wdata;
        `PTS_A_OPD: opd_ff <= bus_wdata[20:0];
        `PTS_A_RLD: rld_ff <= bus_wdata[20:0];
        `PTS_A_IMSK: imsk_ff <= bus_wdata[2:0];
        default: ;
      endcase
    end
  end

  // 1 ms and 20 ms tick generators
  assign ms_tick = (tick_ff == 32'(TICK_CYC - 1));
  assign win_tick = (win_ff == 32'(WIN_CYC - 1));
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tick_ff <= '0;
      win_ff <= '0;
    end
    else
    begin
      tick_ff <= ms_tick ? 32'h0000_0000 : tick_ff + 32'h0000_0001;
      win_ff <= win_tick ? 32'h0000_0000 : win_ff + 32'h0000_0001;
    end
  end

  // per magnitude: scaling, 20 ms change, comparator
  for (genvar g = 0; g < 3; g++)
  begin : g_mag
    logic signed [DW+31:0] prod;
    assign prod = meas[g] * scl_ff[g];
    always_ff @(posedge clk)
    begin
      if (reset)
      begin
        scaled_ff[g] <= '0;
        prev_ff[g] <= '0;
        ref_ff[g] <= '0;
        delta_ff[g] <= '0;
        held_ff[g] <= 1'b0;
      end
      else
      begin
        scaled_ff[g] <= sat(WW'(prod >>> 16)); // [RQ2]
        held_ff[g] <= pick[g] & sel_ff[g];
        if (win_tick)
        begin
          prev_ff[g] <= scaled_ff[g];
          ref_ff[g] <= prev_ff[g];
          delta_ff[g] <= sat(WW'(scaled_ff[g]) - WW'(prev_ff[g])); // [RQ14]
        end
      end
    end
    pts_compare #(.DW(DW)) u_cmp (
      .value(scaled_ff[g]),
      .delta(delta_ff[g]),
      .prev(ref_ff[g]),
      .mode(mode_ff[g]),
      .thr(thr_ff[g]),
      .hys(hys_ff[g]),
      .blk_lim(blk_ff[g]),
      .held(held_ff[g]),
      .pick(pick[g])
    );
  end

  // only selected magnitudes can pick the stage up
  assign pick_any = |(pick & sel_ff); // [RQ1]
  assign off = (behav_ff == pts_pkg::PTS_B_OFF);
  assign test = (behav_ff == pts_pkg::PTS_B_TEST) || (behav_ff == pts_pkg::PTS_B_TEST_BLK);
  assign blk_eff = blk_in_ff || (behav_ff == pts_pkg::PTS_B_BLOCKED) ||
                   (behav_ff == pts_pkg::PTS_B_TEST_BLK);

  // block delayed to line up with scaled_ff; else block and pick-up
  // dropping together would show a start held for the release delay
  always_ff @(posedge clk)
  begin
    if (reset)
      blk_in_ff <= 1'b0;
    else
      blk_in_ff <= block_in; // [RQ13]
  end

  // calculated magnitude: sum of the selected scaled values
  always_ff @(posedge clk)
  begin
    if (reset)
      calc_ff <= '0;
    else
      calc_ff <= sat((sel_ff[0] ? WW'(scaled_ff[0]) : '0) +
                     (sel_ff[1] ? WW'(scaled_ff[1]) : '0) +
                     (sel_ff[2] ? WW'(scaled_ff[2]) : '0));
  end

  // one shared divider walks the four ratios in turn; trades latency for area
  assign rv = (rsel_ff == 2'd3) ? calc_ff : scaled_ff[rsel_ff];
  assign rt = (rsel_ff == 2'd3) ? cthr_ff : thr_ff[rsel_ff];
  assign div_go = first_ff | go_ff;
  assign div_num = WW'((rv < 0) ? -rv : rv) * WW'(`PTS_RATIO_ONE);
  assign div_den = DW'((rt < 0) ? -rt : rt);
  pts_divider #(.NW(WW), .DW(DW)) u_div (
    .clk(clk),
    .reset(reset),
    .start(div_go),
    .num(div_num),
    .den(div_den),
    .done(div_done),
    .quo(div_quo)
  );
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      first_ff <= 1'b1;
      go_ff <= 1'b0;
      rsel_ff <= '0;
      neg_ff <= 1'b0;
      for (int i = 0; i < 4; i++)
        ratio_ff[i] <= '0;
    end
    else
    begin
      first_ff <= 1'b0;
      // restart a cycle after done so the mux shows the next index
      go_ff <= div_done;
      if (div_done)
      begin
        // zero threshold divides to all ones and so clamps
        if (div_quo > WW'(VMAX))
          ratio_ff[rsel_ff] <= neg_ff ? DW'(-VMAX) : DW'(VMAX); // [RQ3]
        else
          ratio_ff[rsel_ff] <= neg_ff ? -DW'(div_quo) : DW'(div_quo); // [RQ3]
        rsel_ff <= rsel_ff + 2'd1;
      end
      if (div_go)
        neg_ff <= (rv < 0) ^ (rt < 0);
    end
  end

  // stage sequence
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      pts_pkg::PTS_NORMAL:
        if (pick_any)
          nxt_state = blk_eff ? pts_pkg::PTS_BLOCKED : pts_pkg::PTS_START; // [RQ13] [RQ16]
      pts_pkg::PTS_START:
        if (blk_eff)
          nxt_state = pts_pkg::PTS_REL_BLOCK; // [RQ16]
        else if (!pick_any)
          nxt_state = pts_pkg::PTS_REL_START; // [RQ17]
        else if (op_cnt_ff >= opd_ff)
          nxt_state = pts_pkg::PTS_TRIP; // [RQ17]
      pts_pkg::PTS_TRIP:
        if (blk_eff)
          nxt_state = pts_pkg::PTS_REL_BLOCK; // [RQ16]
        else if (!pick_any)
          nxt_state = pts_pkg::PTS_REL_TRIP;
      pts_pkg::PTS_BLOCKED:
        if (!pick_any)
          nxt_state = pts_pkg::PTS_NORMAL;
        else if (!blk_eff)
          nxt_state = pts_pkg::PTS_START; // [RQ13]
      pts_pkg::PTS_REL_START, pts_pkg::PTS_REL_TRIP:
        if (blk_eff)
          nxt_state = pts_pkg::PTS_REL_BLOCK; // [RQ16]
        else if (pick_any)
          nxt_state = (state_ff == pts_pkg::PTS_REL_TRIP) ? pts_pkg::PTS_TRIP : pts_pkg::PTS_START;
        else if (rl_cnt_ff >= rld_ff)
          nxt_state = pts_pkg::PTS_NORMAL; // [RQ17]
      pts_pkg::PTS_REL_BLOCK:
        if (rl_cnt_ff >= rld_ff)
          nxt_state = pts_pkg::PTS_NORMAL; // [RQ16]
      default: nxt_state = pts_pkg::PTS_NORMAL;
    endcase
    if (off)
      nxt_state = pts_pkg::PTS_NORMAL;
    case (nxt_state)
      pts_pkg::PTS_START, pts_pkg::PTS_REL_START: nxt_cond = pts_pkg::PTS_C_START;
      pts_pkg::PTS_TRIP, pts_pkg::PTS_REL_TRIP: nxt_cond = pts_pkg::PTS_C_TRIP;
      pts_pkg::PTS_BLOCKED: nxt_cond = pts_pkg::PTS_C_BLOCKED;
      default: nxt_cond = pts_pkg::PTS_C_NORMAL;
    endcase
  end

  // start held through release unless blocking ended it
  assign ev[0] = (nxt_cond == pts_pkg::PTS_C_START) && (cond_ff != pts_pkg::PTS_C_START);
  assign ev[1] = (nxt_cond == pts_pkg::PTS_C_TRIP) && (cond_ff != pts_pkg::PTS_C_TRIP);
  assign ev[2] = (nxt_cond == pts_pkg::PTS_C_BLOCKED) && (cond_ff != pts_pkg::PTS_C_BLOCKED);
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_ff <= pts_pkg::PTS_NORMAL;
      cond_ff <= pts_pkg::PTS_C_NORMAL;
      start_out <= 1'b0;
      trip_out <= 1'b0;
      blocked_out <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cond_ff <= nxt_cond; // [RQ4]
      start_out <= (nxt_cond == pts_pkg::PTS_C_START);
      trip_out <= (nxt_cond == pts_pkg::PTS_C_TRIP) && !test; // test mode withholds trip
      blocked_out <= (nxt_cond == pts_pkg::PTS_C_BLOCKED);
    end
  end

  // delay counters in 1 ms steps; 5 ms settings land on whole counts
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      op_cnt_ff <= '0;
      rl_cnt_ff <= '0;
      remain_ff <= '0;
      expect_ff <= '0;
    end
    else
    begin
      if (state_ff == pts_pkg::PTS_START || state_ff == pts_pkg::PTS_REL_START)
        op_cnt_ff <= op_cnt_ff + {20'h0_0000, ms_tick && op_cnt_ff < `PTS_TMAX}; // [RQ17]
      else
        op_cnt_ff <= '0;
      if (state_ff == pts_pkg::PTS_REL_START || state_ff == pts_pkg::PTS_REL_TRIP ||
          state_ff == pts_pkg::PTS_REL_BLOCK)
        rl_cnt_ff <= rl_cnt_ff + {20'h0_0000, ms_tick && rl_cnt_ff < `PTS_TMAX}; // [RQ17]
      else
        rl_cnt_ff <= '0;
      if (cond_ff == pts_pkg::PTS_C_START && opd_ff > op_cnt_ff)
        remain_ff <= opd_ff - op_cnt_ff; // [RQ6]
      else
        remain_ff <= '0;
      if (cond_ff == pts_pkg::PTS_C_START || cond_ff == pts_pkg::PTS_C_TRIP)
        expect_ff <= $signed({1'b0, opd_ff}); // [RQ7]
      else
        expect_ff <= '0;
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge clk)
  begin
    if (reset)
      ist_ff <= '0;
    else if (bus_wr && bus_addr == `PTS_A_IST)
      ist_ff <= (ist_ff & ~bus_wdata[2:0]) | ev;
    else
      ist_ff <= ist_ff | ev;
  end
  assign irq = |(ist_ff & imsk_ff);

  // read data stands in the cycle after the strobe only
  always_ff @(posedge clk)
  begin
    if (reset || !bus_rd)
      bus_rdata <= '0;
    else
    begin
      bus_rdata <= '0;
      for (int i = 0; i < 3; i++)
      begin
        if (bus_addr == 8'(`PTS_A_THR + 4 * i))
          bus_rdata <= thr_ff[i];
        if (bus_addr == 8'(`PTS_A_HYS + 4 * i))
          bus_rdata <= DW'(hys_ff[i]);
        if (bus_addr == 8'(`PTS_A_BLK + 4 * i))
          bus_rdata <= blk_ff[i];
        if (bus_addr == 8'(`PTS_A_SCL + 4 * i))
          bus_rdata <= DW'(scl_ff[i]);
        if (bus_addr == 8'(`PTS_A_SCALED + 4 * i))
          bus_rdata <= scaled_ff[i]; // [RQ2]
      end
      for (int i = 0; i < 4; i++)
        if (bus_addr == 8'(`PTS_A_RATIO + 4 * i))
          bus_rdata <= ratio_ff[i]; // [RQ3]
      case (bus_addr)
        `PTS_A_CTRL: bus_rdata <= DW'({behav_ff, 1'b0, sel_ff});
        `PTS_A_MODE: bus_rdata <= DW'({mode_ff[2], 1'b0, mode_ff[1], 1'b0, mode_ff[0]});
        `PTS_A_CTHR: bus_rdata <= cthr_ff;
        `PTS_A_OPD: bus_rdata <= DW'(opd_ff);
        `PTS_A_RLD: bus_rdata <= DW'(rld_ff);
        `PTS_A_IST: bus_rdata <= DW'(ist_ff);
        `PTS_A_IMSK: bus_rdata <= DW'(imsk_ff);
        `PTS_A_COND: bus_rdata <= DW'({allow_individual_mode ? behav_ff : 3'h0, 2'h0, cond_ff}); // [RQ5]
        `PTS_A_REMAIN: bus_rdata <= DW'(remain_ff); // [RQ6]
        `PTS_A_EXPECT: bus_rdata <= DW'(expect_ff); // [RQ7]
        default: ;
      endcase
    end
  end

  // checks
  a_cond_start: assert property (@(posedge clk) disable iff (reset) // [RQ4]
    start_out == (cond_ff == pts_pkg::PTS_C_START)) else $error("start and condition differ");
  a_block_gate: assert property (@(posedge clk) disable iff (reset) // [RQ13]
    (state_ff == pts_pkg::PTS_NORMAL && pick_any && blk_eff && !off)
    |=> (blocked_out && !start_out)) else $error("blocked pick-up made start");
  a_start_clean: assert property (@(posedge clk) disable iff (reset) // [RQ13]
    $rose(start_out) |-> !$past(blk_eff)) else $error("start rose while blocked");
  a_late_block: assert property (@(posedge clk) disable iff (reset) // [RQ16]
    (state_ff == pts_pkg::PTS_START && blk_eff) |=> (!start_out && !blocked_out))
    else $error("late block kept start");
  a_trip_delay: assert property (@(posedge clk) disable iff (reset) // [RQ17]
    $rose(cond_ff == pts_pkg::PTS_C_TRIP) && $past(state_ff) == pts_pkg::PTS_START
    |-> $past(op_cnt_ff) >= $past(opd_ff)) else $error("trip before operate delay");
  a_release_hold: assert property (@(posedge clk) disable iff (reset) // [RQ17]
    (state_ff == pts_pkg::PTS_START && !pick_any && !blk_eff && !off && rld_ff != 21'h0)
    |=> start_out [*2]) else $error("start dropped before release delay");
  a_remain_bound: assert property (@(posedge clk) disable iff (reset) // [RQ6]
    remain_ff <= `PTS_TMAX && (remain_ff == 21'h0 || $past(cond_ff) == pts_pkg::PTS_C_START))
    else $error("remaining time out of range");
  a_scaled_range: assert property (@(posedge clk) disable iff (reset) // [RQ2]
    WW'(scaled_ff[0]) <= VMAX && WW'(scaled_ff[0]) >= -VMAX) else $error("scaled value unclamped");
  a_ratio_range: assert property (@(posedge clk) disable iff (reset) // [RQ3]
    WW'(ratio_ff[3]) <= VMAX && WW'(ratio_ff[3]) >= -VMAX) else $error("ratio unclamped");
  a_expect_link: assert property (@(posedge clk) disable iff (reset) // [RQ7]
    (cond_ff == pts_pkg::PTS_C_TRIP) |=> expect_ff == $signed({1'b0, $past(opd_ff)}))
    else $error("expected time wrong");
  c_trip: cover property (@(posedge clk) disable iff (reset) $rose(trip_out));
  c_blocked: cover property (@(posedge clk) disable iff (reset) $rose(blocked_out));
  c_late_block: cover property (@(posedge clk) disable iff (reset)
    state_ff == pts_pkg::PTS_REL_BLOCK);
endmodule
`default_nettype wire

// File: tb/pts_meas_src.sv
// measurement source and blocking matrix model
`timescale 1ns/1ps
`default_nettype none
module pts_meas_src (
  input wire logic clk,
  input wire logic signed [47:0] lvl,
  input wire logic blk,
  output logic signed [47:0] meas_value_0,
  output logic signed [47:0] meas_value_1,
  output logic signed [47:0] meas_value_2,
  output logic block_in
);
  // samples land once per program cycle edge
  always_ff @(posedge clk)
  begin
    meas_value_0 <= lvl;
    meas_value_1 <= -lvl; // unselected channels keep moving
    meas_value_2 <= lvl >>> 1;
    block_in <= blk;
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the threshold stage
`timescale 1ns/1ps
`default_nettype none
`include "pts_params.svh"
module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] bus_addr = 8'h00;
  logic [47:0] bus_wdata = 48'h0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [47:0] bus_rdata;
  logic signed [47:0] lvl = 48'h0;
  logic blk = 1'b0;
  logic allow_individual_mode = 1'b0;
  logic signed [47:0] m0, m1, m2;
  logic block_in, start_out, trip_out, blocked_out, irq;
  logic [2:0] outs;
  int failures = 0;
  int checked = 0;
  int n;
  assign outs = {blocked_out, trip_out, start_out};
  always #4 clk = ~clk;
  pts_meas_src pts_meas_src_i (.clk(clk), .lvl(lvl), .blk(blk), .meas_value_0(m0),
    .meas_value_1(m1), .meas_value_2(m2), .block_in(block_in));
  // short tick and window keep delays to tens of cycles
  pts_stage #(.TICK_CYC(10), .WIN_CYC(20)) pts_stage_i (.clk(clk), .reset(reset),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .meas_value_0(m0), .meas_value_1(m1), .meas_value_2(m2),
    .block_in(block_in), .allow_individual_mode(allow_individual_mode),
    .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out), .irq(irq));
  task automatic end_of_test();
    if (failures == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    checked++;
    if (e !== g)
    begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [47:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
    #1;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [47:0] e);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, bus_rdata);
  endtask
  // bounded wait on start, trip or blocked; n counts cycles
  task automatic wfor(input int k, input logic l, output int c);
    c = 0;
    while (outs[k] !== l)
    begin
      @(posedge clk);
      #1;
      c++;
      if (c > 3000)
      begin
        chk($sformatf("wait %0d", k), {47'h0, l}, {47'h0, ~l});
        end_of_test();
      end
    end
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(`PTS_A_CTRL, 48'h11);
    rd(`PTS_A_MODE, 48'h0);
    rd(`PTS_A_THR, 48'h64);
    rd(`PTS_A_HYS, 48'h7530);
    rd(`PTS_A_SCL, 48'h1_0000);
    rd(`PTS_A_OPD, 48'h28);
    rd(`PTS_A_RLD, 48'h3C);
    rd(`PTS_A_COND, 48'h0);
    rd(8'hFC, 48'h0);
    wr(`PTS_A_COND, 48'h3);
    wr(`PTS_A_OPD, 48'h3);
    wr(`PTS_A_RLD, 48'h2);
    allow_individual_mode <= 1'b1;
    rd(`PTS_A_COND, 48'h10);
    // pick-up, start, then trip after three ticks
    lvl <= 48'hC8;
    wfor(0, 1'b1, n);
    wfor(1, 1'b1, n);
    chk("op delay", 48'h1, {47'h0, n >= 19 && n <= 31});
    chk("irq masked", 48'h0, {47'h0, irq});
    rd(`PTS_A_IST, 48'h3);
    wr(`PTS_A_IMSK, 48'h7);
    chk("irq", 48'h1, {47'h0, irq});
    rd(`PTS_A_COND, 48'h12);
    rd(`PTS_A_EXPECT, 48'h3);
    rd(`PTS_A_SCALED, 48'hC8);
    repeat (400) @(posedge clk);
    rd(`PTS_A_RATIO, 48'h4E20);
    rd(`PTS_A_RATIO + 8'h04, 48'hFFFF_FFFF_B1E0);
    // inside the 3 percent band trip must hold
    lvl <= 48'h62;
    repeat (60) @(posedge clk);
    chk("band", 48'h1, {47'h0, trip_out});
    lvl <= 48'h5A;
    wfor(1, 1'b0, n);
    chk("release", 48'h1, {47'h0, n >= 8 && n <= 25});
    wr(`PTS_A_IST, 48'h7);
    chk("irq clr", 48'h0, {47'h0, irq});
    // blocking present at pick-up
    blk <= 1'b1;
    lvl <= 48'hC8;
    wfor(2, 1'b1, n);
    chk("no start", 48'h0, {47'h0, start_out});
    rd(`PTS_A_COND, 48'h13);
    // blocking after start drops start
    blk <= 1'b0;
    lvl <= 48'h0;
    wfor(2, 1'b0, n);
    lvl <= 48'hC8;
    wfor(0, 1'b1, n);
    blk <= 1'b1;
    wfor(0, 1'b0, n);
    chk("late blk", 48'h1, {47'h0, n <= 5 && !trip_out});
    blk <= 1'b0;
    lvl <= 48'h0;
    repeat (80) @(posedge clk);
    // under mode with a blocking limit of 50
    wr(`PTS_A_BLK, 48'h32);
    wr(`PTS_A_MODE, 48'h2);
    lvl <= 48'h1E;
    repeat (80) @(posedge clk);
    chk("under lim", 48'h0, {47'h0, start_out});
    lvl <= 48'h46;
    wfor(0, 1'b1, n);
    wr(`PTS_A_CTRL, 48'h51);
    wfor(0, 1'b0, n);
    // test behaviour: the stage reaches trip but trip_out stays low
    wr(`PTS_A_CTRL, 48'h31);
    wfor(0, 1'b1, n);
    repeat (40) @(posedge clk);
    chk("test trip", 48'h0, {47'h0, trip_out});
    rd(`PTS_A_COND, 48'h32);
    end_of_test();
  end
endmodule
`default_nettype wire
